// [logic/spcd_defs.vh]
`ifndef SPCD_DEFS_VH
`define SPCD_DEFS_VH
// Strap state codes
`define SPCD_STRAP_LOW         2'h0
`define SPCD_STRAP_HIGH        2'h1
`define SPCD_STRAP_OPEN        2'h2
// Hysteresis end values
`define SPCD_HYST_END_LOW      4'h7
`define SPCD_HYST_END_HIGH     4'hb
`define SPCD_HYST_END_OPEN     4'hf
// Blank time codes
`define SPCD_BLANK_LOW         2'h0
`define SPCD_BLANK_HIGH        2'h1
`define SPCD_BLANK_OPEN        2'h2
// Currents and hold ramp delays
`define SPCD_RUN_CUR_FULL      5'h1f
`define SPCD_HOLD_CUR_FULL     5'h1f
`define SPCD_HOLD_CUR_REDUCED  5'h0b
`define SPCD_HOLD_DLY_OPEN     4'h8
`define SPCD_HOLD_DLY_NONE     4'h0
// Voltage chopper default word and its fields
`define SPCD_VCHOP_WORD_DEFAULT 32'h00050480
`define SPCD_VCHOP_AMPL_LSB     0
`define SPCD_VCHOP_GRAD_LSB     8
`define SPCD_VCHOP_FREQ_LSB     16
`define SPCD_VCHOP_AUTO_BIT     18
// Timing counts in clock cycles
`define SPCD_STANDSTILL_CYC    1048576
`define SPCD_RAMP_CYC          46137344
// Strap sampling
`define SPCD_PROBE_DIV         16
`endif

// [logic/spcd_strap_sense.v]
`timescale 1ns/1ps
`default_nettype none
`include "spcd_defs.vh"
// Three-level strap detector: drives a weak probe high then low and reads back
module spcd_strap_sense (
   input  wire       core_clk_i,  // Core clock
   input  wire       nrst_i,      // Sync reset, active low
   input  wire       probe_en_i,  // Sample pulse
   input  wire       pin_i,       // Raw pad level (async)
   output reg        probe_o,     // Weak probe level
   output reg  [1:0] state_o      // Classified state
);
   reg       meta;     // Sync stage 1
   reg       sync;     // Sync stage 2
   reg       phase;    // 0: probing high, 1: probing low
   reg       seen_hi;  // Level seen under high probe

   // Pin synchroniser
   always @(posedge core_clk_i) begin
      meta <= pin_i;
      sync <= meta;
   end

   // Alternate probe; open pin follows probe, tied pin does not
   always @(posedge core_clk_i) begin
      if (!nrst_i) begin
         phase   <= 1'b0;
         probe_o <= 1'b1;
         seen_hi <= 1'b0;
         state_o <= `SPCD_STRAP_LOW;
      end else if (probe_en_i) begin
         phase   <= ~phase;
         probe_o <= phase;
         if (!phase) begin
            seen_hi <= sync;
         end else if (seen_hi && !sync) begin
            state_o <= `SPCD_STRAP_OPEN;
         end else if (sync) begin
            state_o <= `SPCD_STRAP_HIGH;
         end else begin
            state_o <= `SPCD_STRAP_LOW;
         end
      end
   end
endmodule // spcd_strap_sense
`default_nettype wire

// [logic/spcd_hold_ramp.v]
`timescale 1ns/1ps
`default_nettype none
`include "spcd_defs.vh"
// Standstill detector and linear hold-current ramp
module spcd_hold_ramp #(
   parameter STILL_CYC = `SPCD_STANDSTILL_CYC, // Cycles without step
   parameter RAMP_CYC  = `SPCD_RAMP_CYC        // Ramp length
) (
   input  wire       core_clk_i,   // Core clock
   input  wire       nrst_i,       // Sync reset, active low
   input  wire       active_i,     // Power-down enabled
   input  wire       step_i,       // Synchronised step pulse
   input  wire [4:0] hold_i,       // Target hold current
   output reg        still_o,      // Standstill flag
   output reg  [4:0] current_o     // Present current scale
);
   // Cycles per current unit: the whole descent from run to hold takes RAMP_CYC;
   // a RAMP_CYC below the number of units would give a zero step time
   localparam [31:0] STEP_TIME = RAMP_CYC / (`SPCD_RUN_CUR_FULL - `SPCD_HOLD_CUR_REDUCED);
   reg [31:0] idle_cnt;  // Cycles since last step
   reg [31:0] ramp_cnt;  // Cycles within one unit

   // Idle counter and ramp, a step restores full current at once
   always @(posedge core_clk_i) begin
      if (!nrst_i || !active_i || step_i) begin
         idle_cnt  <= 32'h0;
         ramp_cnt  <= 32'h0;
         still_o   <= 1'b0;
         current_o <= `SPCD_RUN_CUR_FULL;
      end else if (!still_o) begin
         idle_cnt <= idle_cnt + 32'h1;
         if (idle_cnt >= STILL_CYC) begin
            still_o <= 1'b1;
         end
      end else if (current_o > hold_i) begin
         if (ramp_cnt + 32'h1 >= STEP_TIME) begin
            ramp_cnt  <= 32'h0;
            current_o <= current_o - 5'h1;
         end else begin
            ramp_cnt <= ramp_cnt + 32'h1;
         end
      end
   end
endmodule // spcd_hold_ramp
`default_nettype wire

// [logic/spcd_decoder.v]
`timescale 1ns/1ps
`default_nettype none
`include "spcd_defs.vh"
module spcd_decoder #(
   parameter STILL_CYC = `SPCD_STANDSTILL_CYC, // Standstill cycles
   parameter RAMP_CYC  = `SPCD_RAMP_CYC,       // Ramp cycles
   parameter PROBE_DIV = `SPCD_PROBE_DIV       // Probe period in cycles
) (
   input  wire        core_clk_i,               // 200 MHz core clock
   input  wire        nrst_i,                   // Power-on reset, active low
   input  wire        current_mode_strap_i,     // Pad level
   input  wire        hysteresis_strap_i,       // Pad level
   input  wire        blank_time_strap_i,       // Pad level
   input  wire        enable_powerdown_strap_i, // Pad level
   input  wire        microstep_strap_a_i,      // Pad level
   input  wire        microstep_strap_b_i,      // Pad level
   input  wire        step_i,                   // Step pin (async)
   output reg  [5:0]  probe_o,                  // Weak probe drive per strap
   output reg         internal_sense_o,         // Internal sense resistor flag
   output reg         analog_scale_o,           // Analog current scale flag
   output reg  [3:0]  hysteresis_end_field_o,   // Hysteresis end
   output reg  [1:0]  blank_time_field_o,       // Blank time code
   output reg         driver_enable_o,          // Driver enabled
   output reg  [4:0]  run_current_o,            // Run current
   output reg  [4:0]  hold_current_o,           // Hold current
   output reg  [3:0]  hold_ramp_delay_o,        // Hold ramp delay
   output reg  [4:0]  current_scale_o,          // Present current scale
   output reg         standstill_o,             // Standstill flag
   output reg  [31:0] voltage_chopper_config_word_o, // Voltage chopper word
   output reg         voltage_chopper_sel_o,    // Voltage chopper selected
   output reg         serial_if_enable_o        // Serial host ports on
);
   wire [11:0] strap_state;   // Six two-bit states
   wire [5:0]  probe_w;       // Probe levels from detectors
   wire [5:0]  pins;          // Strap pads
   reg  [7:0]  div_cnt;       // Probe divider
   reg         probe_en;      // Sample enable pulse
   reg         step_meta;     // Step sync 1
   reg         step_sync;     // Step sync 2
   reg         step_last;     // Previous step level
   wire        step_edge;     // Rising step
   wire        still_w;       // From ramp
   wire [4:0]  scale_w;       // From ramp
   wire [1:0]  cur_st;        // Current mode strap
   wire [1:0]  hys_st;        // Hysteresis strap
   wire [1:0]  blank_st;      // Blank strap
   wire [3:0]  blank_pick;    // Blank code before trimming to two bits
   wire [1:0]  en_st;         // Enable strap
   wire [1:0]  msa_st;        // Microstep a
   wire [1:0]  msb_st;        // Microstep b
   wire        pd_active;     // Power-down mode active

   assign pins = {microstep_strap_b_i, microstep_strap_a_i, enable_powerdown_strap_i,
                  blank_time_strap_i, hysteresis_strap_i, current_mode_strap_i};
   assign cur_st = strap_state[1:0];
   assign hys_st = strap_state[3:2];
   assign blank_st = strap_state[5:4];
   assign en_st  = strap_state[7:6];
   assign msa_st = strap_state[9:8];
   assign msb_st = strap_state[11:10];

   // Select one of three values by strap state
   function [3:0] spcd_pick;
      input [1:0] st;
      input [3:0] v_low;
      input [3:0] v_high;
      input [3:0] v_open;
      begin
         if (st == `SPCD_STRAP_HIGH) begin
            spcd_pick = v_high;
         end else if (st == `SPCD_STRAP_OPEN) begin
            spcd_pick = v_open;
         end else begin
            spcd_pick = v_low;
         end
      end
   endfunction

   // Probe sampling divider: slow so the weak probe can settle the pad
   always @(posedge core_clk_i) begin
      if (!nrst_i) begin
         div_cnt  <= 8'h0;
         probe_en <= 1'b0;
      end else if (div_cnt == PROBE_DIV[7:0] - 8'h1) begin
         div_cnt  <= 8'h0;
         probe_en <= 1'b1;
      end else begin
         div_cnt  <= div_cnt + 8'h1;
         probe_en <= 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_sense
         spcd_strap_sense u_sense (
            .core_clk_i (core_clk_i),
            .nrst_i     (nrst_i),
            .probe_en_i (probe_en),
            .pin_i      (pins[g]),
            .probe_o    (probe_w[g]),
            .state_o    (strap_state[2*g+1:2*g])
         );
      end
   endgenerate

   // Step pin synchroniser and edge detect
   always @(posedge core_clk_i) begin
      if (!nrst_i) begin
         step_meta <= 1'b0;
         step_sync <= 1'b0;
         step_last <= 1'b0;
      end else begin
         step_meta <= step_i;
         step_sync <= step_meta;
         step_last <= step_sync;
      end
   end
   assign step_edge = step_sync & ~step_last;

   // Power-down only with the enable strap open
   assign pd_active = (en_st == `SPCD_STRAP_OPEN);

   // blank code picked at the shared width, trimmed on purpose below
   assign blank_pick = spcd_pick(blank_st, {2'h0, `SPCD_BLANK_LOW}, {2'h0, `SPCD_BLANK_HIGH},
                                 {2'h0, `SPCD_BLANK_OPEN});

   spcd_hold_ramp #(
      .STILL_CYC (STILL_CYC),
      .RAMP_CYC  (RAMP_CYC)
   ) u_ramp (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .active_i   (pd_active),
      .step_i     (step_edge),
      .hold_i     (`SPCD_HOLD_CUR_REDUCED),
      .still_o    (still_w),
      .current_o  (scale_w)
   );

   // Registered outputs; reset loads defaults, then decode follows straps
   always @(posedge core_clk_i) begin
      if (!nrst_i) begin
         probe_o                       <= 6'h3f;
         internal_sense_o              <= 1'b0;
         analog_scale_o                <= 1'b0;
         hysteresis_end_field_o        <= `SPCD_HYST_END_LOW;
         blank_time_field_o            <= `SPCD_BLANK_LOW;
         driver_enable_o               <= 1'b0;
         run_current_o                 <= `SPCD_RUN_CUR_FULL;
         hold_current_o                <= `SPCD_HOLD_CUR_FULL;
         hold_ramp_delay_o             <= `SPCD_HOLD_DLY_NONE;
         current_scale_o               <= `SPCD_RUN_CUR_FULL;
         standstill_o                  <= 1'b0;
         voltage_chopper_config_word_o <= `SPCD_VCHOP_WORD_DEFAULT;
         voltage_chopper_sel_o         <= 1'b0;
         serial_if_enable_o            <= 1'b0;
      end else begin
         probe_o <= probe_w;
         internal_sense_o <= (cur_st == `SPCD_STRAP_HIGH);
         analog_scale_o <= (cur_st == `SPCD_STRAP_OPEN);
         hysteresis_end_field_o <= spcd_pick(hys_st, `SPCD_HYST_END_LOW, `SPCD_HYST_END_HIGH,
                                             `SPCD_HYST_END_OPEN);
         // blank time decode, upper pick bits are always zero
         blank_time_field_o <= blank_pick[1:0];
         driver_enable_o <= (en_st != `SPCD_STRAP_HIGH);
         run_current_o   <= `SPCD_RUN_CUR_FULL;
         if (pd_active) begin
            hold_current_o    <= `SPCD_HOLD_CUR_REDUCED;
            hold_ramp_delay_o <= `SPCD_HOLD_DLY_OPEN;
         end else begin
            hold_current_o    <= `SPCD_HOLD_CUR_FULL;
            hold_ramp_delay_o <= `SPCD_HOLD_DLY_NONE;
         end
         current_scale_o <= scale_w;
         standstill_o    <= still_w;
         voltage_chopper_config_word_o <= `SPCD_VCHOP_WORD_DEFAULT;
         voltage_chopper_sel_o <= (msb_st == `SPCD_STRAP_OPEN) &&
                                  (msa_st != `SPCD_STRAP_LOW);
         serial_if_enable_o <= 1'b0;
      end
   end
endmodule // spcd_decoder
`default_nettype wire

// [dv/spcd_pad_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "spcd_defs.vh"
// Board straps: each pad tied low, tied high or left open
module spcd_pad_model (
   input  wire logic [11:0] mode_i,  // Two bits per strap
   input  wire logic [5:0]  probe_i, // Weak probe drive
   output logic      [5:0]  pad_o    // Pad levels
);
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         case (mode_i[2*k +: 2])
            `SPCD_STRAP_LOW:  pad_o[k] = 1'b0;
            `SPCD_STRAP_HIGH: pad_o[k] = 1'b1;
            // An open pad has no driver, so only the weak probe sets it
            default:          pad_o[k] = probe_i[k];
         endcase
      end
   end
endmodule // spcd_pad_model
`default_nettype wire

// [dv/spcd_decoder_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// Port checks on the strap decoder
module spcd_decoder_monitor #(
   parameter STILL_CYC = 20 // Idle cycles before standstill
) (
   input wire logic        core_clk_i,  // Clock
   input wire logic        nrst_i,      // Reset
   input wire logic        step_i,      // Step pin
   input wire logic        internal_sense_o,  // Sense flag
   input wire logic        analog_scale_o,    // Scale flag
   input wire logic [4:0]  run_current_o,     // Run current
   input wire logic [4:0]  hold_current_o,    // Hold current
   input wire logic [3:0]  hold_ramp_delay_o, // Ramp delay
   input wire logic [4:0]  current_scale_o,   // Present scale
   input wire logic        standstill_o,      // Standstill
   input wire logic [31:0] voltage_chopper_config_word_o, // Chopper word
   input wire logic        voltage_chopper_sel_o,         // Chopper select
   input wire logic        serial_if_enable_o             // Serial ports
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   logic [31:0] idle_cnt; // Cycles since the last step
   // Restart on reset or step; the step pin is async so this is a lower bound
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || step_i) idle_cnt <= 32'h0;
      else idle_cnt <= idle_cnt + 32'h1;
   end
   chk_sense_exclusive: assert property (!(internal_sense_o && analog_scale_o))
      else $error("both sense flags set");
   chk_run_full: assert property (run_current_o == 5'h1f)
      else $error("run current not full");
   chk_still_idle: assert property ($rose(standstill_o) |-> idle_cnt >= STILL_CYC)
      else $error("standstill too early");
   chk_step_wakes: assert property ($rose(step_i) |->
      ##[1:6] (!standstill_o && current_scale_o == 5'h1f))
      else $error("step did not restore current");
   chk_ramp_unit: assert property (current_scale_o < $past(current_scale_o) |->
      standstill_o && current_scale_o == $past(current_scale_o) - 5'h01)
      else $error("ramp step wrong");
   chk_scale_floor: assert property (current_scale_o >= 5'h0b)
      else $error("scale below hold");
   chk_delay_pair: assert property (hold_current_o == 5'h0b |-> hold_ramp_delay_o == 4'h8)
      else $error("hold delay wrong");
   chk_word_const: assert property (voltage_chopper_config_word_o == 32'h00050480)
      else $error("chopper word changed");
   chk_serial_off: assert property (serial_if_enable_o == 1'b0)
      else $error("serial ports on");
   cover property ($rose(standstill_o));
   cover property (current_scale_o == 5'h0b);
   cover property (voltage_chopper_sel_o);
   cover property (analog_scale_o);
endmodule // spcd_decoder_monitor
bind spcd_decoder spcd_decoder_monitor #(.STILL_CYC(STILL_CYC)) u_mon (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .step_i(step_i),
   .internal_sense_o(internal_sense_o), .analog_scale_o(analog_scale_o),
   .run_current_o(run_current_o), .hold_current_o(hold_current_o),
   .hold_ramp_delay_o(hold_ramp_delay_o), .current_scale_o(current_scale_o),
   .standstill_o(standstill_o), .voltage_chopper_sel_o(voltage_chopper_sel_o),
   .voltage_chopper_config_word_o(voltage_chopper_config_word_o),
   .serial_if_enable_o(serial_if_enable_o));
`default_nettype wire

// [dv/spcd_decoder_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// Strap decoder bench; strap codes 0 low, 1 high, 2 open
module spcd_decoder_bench;
   logic        core_clk_i = 1'b0; // Clock
   logic        nrst_i     = 1'b0; // Reset
   logic        step_i     = 1'b0; // Step pin
   logic [11:0] mode       = 12'h0; // Strap states
   logic [5:0]  probe, pad;         // Probe and pads
   logic        sense, scale, en, still, sel, serial;
   logic [3:0]  hyst, dly;
   logic [1:0]  blank;
   logic [4:0]  run, hold, cur;
   logic [31:0] word;
   int          fails = 0, cmp_count = 0, cycles = 0;
   spcd_pad_model u_pads (.mode_i(mode), .probe_i(probe), .pad_o(pad));
   // Short counts keep the ramp scenario brief; 40 gives two cycles per unit
   spcd_decoder #(.STILL_CYC(20), .RAMP_CYC(40), .PROBE_DIV(16)) uut (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .current_mode_strap_i(pad[0]),
      .hysteresis_strap_i(pad[1]), .blank_time_strap_i(pad[2]),
      .enable_powerdown_strap_i(pad[3]), .microstep_strap_a_i(pad[4]),
      .microstep_strap_b_i(pad[5]), .step_i(step_i), .probe_o(probe),
      .internal_sense_o(sense), .analog_scale_o(scale), .hysteresis_end_field_o(hyst),
      .blank_time_field_o(blank), .driver_enable_o(en), .run_current_o(run),
      .hold_current_o(hold), .hold_ramp_delay_o(dly), .current_scale_o(cur),
      .standstill_o(still), .voltage_chopper_config_word_o(word),
      .voltage_chopper_sel_o(sel), .serial_if_enable_o(serial));
   always #2.5 core_clk_i = ~core_clk_i;
   // Hang guard; the full run needs under 1500 cycles
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         test_done();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Let n edges pass, then sample at the falling edge
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask
   task automatic pulse_step;
      @(posedge core_clk_i);
      step_i <= 1'b1;
      @(posedge core_clk_i);
      step_i <= 1'b0;
   endtask
   task automatic t_reset;
      @(posedge core_clk_i);
      nrst_i <= 1'b0;
      settle(12);
      check(hyst, 32'h7);
      check({en, blank, cur, run}, {1'b0, 2'h0, 5'h1f, 5'h1f});
      check(word, 32'h00050480);
      @(posedge core_clk_i);
      nrst_i <= 1'b1;
      $display("test reset done");
   endtask
   // Fourth pass returns to low with no reset in between
   task automatic t_straps;
      logic [1:0] s;
      for (int i = 0; i < 4; i++) begin
         s = 2'(i % 3);
         @(posedge core_clk_i);
         mode <= {4'h0, {4{s}}};
         // A change just missed by a high-probe sample needs about 51 cycles
         settle(56);
         check(sense, s == 2'h1);
         check(scale, s == 2'h2);
         check(hyst, s == 2'h0 ? 4'h7 : s == 2'h1 ? 4'hb : 4'hf);
         check(blank, s);
         check(en, s != 2'h1);
         check(hold, s == 2'h2 ? 5'h0b : 5'h1f);
         check(dly, s == 2'h2 ? 4'h8 : 4'h0);
      end
      $display("test straps done");
   endtask
   task automatic t_chopper;
      for (int a = 0; a < 3; a++) begin
         for (int b = 0; b < 3; b++) begin
            @(posedge core_clk_i);
            mode <= {2'(b), 2'(a), 8'h55};
            settle(56);
            check(sel, b == 2 && a != 0);
            check(word, 32'h00050480);
            check(word[18:0], {1'b1, 2'h1, 8'h04, 8'h80});
            check({serial, run}, {1'b0, 5'h1f});
         end
      end
      $display("test chopper done");
   endtask
   task automatic t_standstill;
      int n;
      @(posedge core_clk_i);
      mode <= 12'h080;
      settle(56);
      pulse_step();
      settle(16);
      check({still, cur}, {1'b0, 5'h1f});
      n = 0;
      while (still !== 1'b1 && n < 40) begin
         @(negedge core_clk_i);
         n++;
      end
      check(n > 0 && n < 12, 1'b1);
      n = 0;
      while (cur !== 5'h0b && n < 80) begin
         @(negedge core_clk_i);
         n++;
      end
      check(n >= 36 && n <= 46, 1'b1);
      pulse_step();
      settle(8);
      check({still, cur}, {1'b0, 5'h1f});
      settle(60);
      $display("test standstill done");
   endtask
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      t_reset();
      t_straps();
      t_chopper();
      t_standstill();
      t_reset();
      test_done();
   end
endmodule // spcd_decoder_bench
`default_nettype wire
